// [inc/atcc_pkg.sv]
// package of the adjustable time counter with capture
// assumes a simple register port with word offsets and single-cycle strobes
package atcc_pkg;
    // ============================================================
    // register offsets
    localparam logic [7:0]  OFS_GLB_CFG  = 8'h00;
    localparam logic [7:0]  OFS_WRAP     = 8'h04;
    localparam logic [7:0]  OFS_RATE_ADJ = 8'h08;
    localparam logic [7:0]  OFS_COUNT    = 8'h0C;
    localparam logic [7:0]  OFS_CAP_CFG  = 8'h10;
    localparam logic [7:0]  OFS_CAP_STS  = 8'h14;
    localparam logic [7:0]  OFS_CAP_VAL0 = 8'h18;
    localparam logic [7:0]  OFS_CAP_VALN = 8'h3C;
    // ============================================================
    // field layout and reset values
    localparam int          RUN_BIT      = 0;
    localparam int          NSTEP_LO     = 4;
    localparam int          NSTEP_HI     = 7;
    localparam int          ASTEP_LO     = 8;
    localparam int          ASTEP_HI     = 19;
    localparam int          SYNC_LO      = 10;
    localparam int          SYNC_HI      = 17;
    localparam int          MODE_HI      = 9;
    localparam int          ADJ_HI       = 23;
    localparam int          CAP_VALID_B  = 10;
    localparam int          N_INPUTS     = 8;
    localparam int          N_SLOTS      = 10;
    localparam logic [3:0]  NSTEP_RST    = 4'h5;
    localparam logic [11:0] ASTEP_RST    = 12'h005;
    localparam logic [17:0] CAP_CFG_RST  = 18'h1FC00;
    localparam logic [31:0] COUNT_MAX    = 32'hFFFFFFFF;
    // ============================================================
    // register request bundle
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } atcc_req_s;
endpackage

// [hw/atcc_capture_slot.sv]
// one capture slot: latches the time value on an event
// assumes event is a single-cycle pulse on the same clock
module atcc_capture_slot (
    input  wire logic        ref_clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        event_in,
    input  wire logic        first_hit_mode_in,
    input  wire logic        clear_in,
    input  wire logic [31:0] count_in,
    output logic      [31:0] value_out,
    output logic             valid_out
);
    // ============================================================
    // capture decision
    wire take = event_in & (~first_hit_mode_in | ~valid_out | clear_in);
    // a clear in the same cycle as a new first-hit mode hit keeps the flag set
    wire next_valid = (event_in & first_hit_mode_in) | (valid_out & ~clear_in);

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            value_out <= 32'h00000000;
            valid_out <= 1'b0;
        end else begin
            if (take) begin
                value_out <= count_in;
            end
            valid_out <= next_valid;
        end
    end

    // ============================================================
    // checks
    AST_CONT_NO_STATUS: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (event_in && !first_hit_mode_in && !valid_out) |=> (!valid_out && value_out == $past(count_in)))
        else $error("continuous capture wrong");
    AST_FIRST_HOLD: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (valid_out && first_hit_mode_in && !clear_in) |=> (valid_out && $stable(value_out)))
        else $error("first-hit value not held");
    AST_FIRST_SET: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (event_in && first_hit_mode_in && !valid_out) |=> (valid_out && value_out == $past(count_in)))
        else $error("first hit not latched");
endmodule // atcc_capture_slot

// [hw/atcc_timer.sv]
// adjustable time counter with wrap flag and ten capture slots
// assumes one register request per cycle; read data is valid the cycle after rd
// Operation
// - on rollover from all ones, set sticky wrap flag and keep counting
// - add normal or adjusted step to the 32-bit count every rising clock edge while run is set and the count is not written
// - while rate-adjust count nonzero use adjusted step and decrement it
// - rate-adjust count zero means normal step
// - reading rate-adjust returns the live remaining count
// - sync-enable bits 17..10, one per input, reset 7Fh
// - continuous mode captures every event without setting status
// - first-hit mode latches first event, sets status, holds until cleared
// - mode bits 5..0 rise0-5, 6 rise6, 7 fall6, 8 rise7, 9 fall7
// - run bit zero holds the count, one lets it count
// - normal step bits 7..4, adjusted step bits 19..8, both reset 5h
module atcc_timer (
    input  wire logic                      ref_clk_in,
    input  wire logic                      rst_b_in,
    input  wire atcc_pkg::atcc_req_s       reg_req_in,
    input  wire logic [7:0]                cap_in,
    output logic      [31:0]               reg_rdata_out
);
    // ============================================================
    // registers
    logic                 run;
    logic [3:0]           normal_step;
    logic [11:0]          adjusted_step;
    logic                 wrap_flag;
    logic [23:0]          rate_adjust;
    logic [31:0]          time_count;
    logic [17:0]          capture_setup;

    // ============================================================
    // address decode
    wire hit_cfg   = reg_req_in.addr == atcc_pkg::OFS_GLB_CFG;
    wire hit_wrap  = reg_req_in.addr == atcc_pkg::OFS_WRAP;
    wire hit_adj   = reg_req_in.addr == atcc_pkg::OFS_RATE_ADJ;
    wire hit_cnt   = reg_req_in.addr == atcc_pkg::OFS_COUNT;
    wire hit_ccfg  = reg_req_in.addr == atcc_pkg::OFS_CAP_CFG;
    wire hit_csts  = reg_req_in.addr == atcc_pkg::OFS_CAP_STS;
    wire hit_cval  = (reg_req_in.addr >= atcc_pkg::OFS_CAP_VAL0)
                   && (reg_req_in.addr <= atcc_pkg::OFS_CAP_VALN)
                   && (reg_req_in.addr[1:0] == 2'h0);
    wire wr_cfg    = reg_req_in.wr & hit_cfg;
    wire wr_wrap   = reg_req_in.wr & hit_wrap;
    wire wr_adj    = reg_req_in.wr & hit_adj;
    wire wr_cnt    = reg_req_in.wr & hit_cnt;
    wire wr_ccfg   = reg_req_in.wr & hit_ccfg;
    wire rd_csts   = reg_req_in.rd & hit_csts;
    wire [7:0] val_ofs = reg_req_in.addr - atcc_pkg::OFS_CAP_VAL0;
    wire [3:0] val_idx = val_ofs[5:2];

    // ============================================================
    // counter datapath
    wire        adj_active = rate_adjust != 24'h000000;
    wire [31:0] step       = adj_active ? {20'h00000, adjusted_step}
                                        : {28'h0000000, normal_step};
    wire [32:0] sum        = {1'b0, time_count} + {1'b0, step};
    wire        wrapped    = run & ~wr_cnt & sum[32];
    wire [31:0] next_count = wr_cnt ? (time_count & ~reg_req_in.wdata)
                           : run    ? sum[31:0]
                                    : time_count;
    // the hardware set wins over a software clear in the same cycle
    wire next_wrap = wrapped | (wrap_flag & ~(wr_wrap & reg_req_in.wdata[0]));
    wire [23:0] next_adj = wr_adj     ? reg_req_in.wdata[atcc_pkg::ADJ_HI:0]
                         : adj_active ? rate_adjust - 24'h000001
                                      : rate_adjust;

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            time_count  <= 32'h00000000;
            wrap_flag   <= 1'b0;
            rate_adjust <= 24'h000000;
        end else begin
            time_count  <= next_count;
            wrap_flag   <= next_wrap;
            rate_adjust <= next_adj;
        end
    end

    // ============================================================
    // configuration registers
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            run           <= 1'b0;
            normal_step   <= atcc_pkg::NSTEP_RST;
            adjusted_step <= atcc_pkg::ASTEP_RST;
            capture_setup <= atcc_pkg::CAP_CFG_RST;
        end else begin
            if (wr_cfg) begin
                run           <= reg_req_in.wdata[atcc_pkg::RUN_BIT];
                normal_step   <= reg_req_in.wdata[atcc_pkg::NSTEP_HI:atcc_pkg::NSTEP_LO];
                adjusted_step <= reg_req_in.wdata[atcc_pkg::ASTEP_HI:atcc_pkg::ASTEP_LO];
            end
            if (wr_ccfg) begin
                capture_setup <= reg_req_in.wdata[atcc_pkg::SYNC_HI:0];
            end
        end
    end

    // ============================================================
    // capture inputs: optional three-stage synchroniser
    wire [7:0] sync_en = capture_setup[atcc_pkg::SYNC_HI:atcc_pkg::SYNC_LO];
    wire [9:0] mode    = capture_setup[atcc_pkg::MODE_HI:0];
    wire [7:0] level;
    wire [7:0] rise;
    wire [7:0] fall;

    genvar gi;
    generate
        for (gi = 0; gi < atcc_pkg::N_INPUTS; gi = gi + 1) begin : g_in
            logic sync_s1;
            logic sync_s2;
            logic sync_s3;
            logic filt;
            logic raw_q;
            logic prev;
            // raw path exists for inputs already on this clock; async use is unsafe
            assign level[gi] = sync_en[gi] ? filt : raw_q;
            assign rise[gi]  = level[gi] & ~prev;
            assign fall[gi]  = ~level[gi] & prev;
            always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    sync_s1 <= 1'b0;
                    sync_s2 <= 1'b0;
                    sync_s3 <= 1'b0;
                    filt    <= 1'b0;
                    raw_q   <= 1'b0;
                    prev    <= 1'b0;
                end else begin
                    sync_s1 <= cap_in[gi];
                    sync_s2 <= sync_s1;
                    sync_s3 <= sync_s2;
                    if (sync_s2 == sync_s3) begin
                        filt <= sync_s3;
                    end
                    raw_q   <= cap_in[gi];
                    prev    <= level[gi];
                end
            end
            AST_RAW_FOLLOW: assert property (
                @(posedge ref_clk_in) disable iff (!rst_b_in)
                (!sync_en[gi] && !wr_ccfg) |=> level[gi] == $past(cap_in[gi]))
                else $error("unsynchronised input not passed through one flop");
            AST_SYNC_FILTER: assert property (
                @(posedge ref_clk_in) disable iff (!rst_b_in)
                (sync_en[gi] && !wr_ccfg && $past(rst_b_in, 3)
                    && $past(cap_in[gi], 2) == $past(cap_in[gi], 3))
                |=> level[gi] == $past(cap_in[gi], 4))
                else $error("synchronised input not taken after agreement");
        end
    endgenerate

    // ============================================================
    // capture slots: rise0-5, rise6, fall6, rise7, fall7
    wire [9:0]  slot_event = {fall[7], rise[7], fall[6], rise[6], rise[5:0]};
    logic [9:0]  slot_valid;
    logic [31:0] slot_value [atcc_pkg::N_SLOTS];

    generate
        for (gi = 0; gi < atcc_pkg::N_SLOTS; gi = gi + 1) begin : g_slot
            atcc_capture_slot u_slot (
                .ref_clk_in        (ref_clk_in),
                .rst_b_in          (rst_b_in),
                .event_in          (slot_event[gi]),
                .first_hit_mode_in (mode[gi]),
                .clear_in          (rd_csts),
                .count_in          (time_count),
                .value_out         (slot_value[gi]),
                .valid_out         (slot_valid[gi])
            );
        end
    endgenerate

    // ============================================================
    // read mux
    wire [31:0] cap_sts  = {8'h00, level, 5'h00, |slot_valid, slot_valid};
    wire [31:0] cfg_word = {12'h000, adjusted_step, normal_step, 3'h0, run};
    wire [31:0] val_word = (val_idx < 4'(atcc_pkg::N_SLOTS)) ? slot_value[val_idx] : 32'h00000000;
    wire [31:0] next_rdata =
          hit_cfg  ? cfg_word
        : hit_wrap ? {31'h00000000, wrap_flag}
        : hit_adj  ? {8'h00, rate_adjust}
        : hit_cnt  ? time_count
        : hit_ccfg ? {14'h0000, capture_setup}
        : hit_csts ? cap_sts
        : hit_cval ? val_word
                   : 32'h00000000;

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            reg_rdata_out <= 32'h00000000;
        end else if (reg_req_in.rd) begin
            reg_rdata_out <= next_rdata;
        end
    end

    // ============================================================
    // checks
    AST_WRAP_SET: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (run && !wr_cnt && time_count == atcc_pkg::COUNT_MAX && step != 32'h0)
        |=> (wrap_flag && time_count == $past(step) - 32'h1))
        else $error("rollover did not set wrap flag");
    AST_STEP_ADD: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (run && !wr_cnt) |=> time_count == $past(time_count) + $past(step))
        else $error("count did not advance by step");
    AST_ADJ_DEC: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (adj_active && !wr_adj) |=> rate_adjust == $past(rate_adjust) - 24'h1)
        else $error("rate-adjust count not decremented");
    AST_ADJ_STEP: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (adj_active && run && !wr_cnt)
        |=> time_count == $past(time_count) + {20'h00000, $past(adjusted_step)})
        else $error("adjusted step not used");
    AST_NORM_STEP: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (!adj_active && run && !wr_cnt)
        |=> time_count == $past(time_count) + {28'h0000000, $past(normal_step)})
        else $error("normal step not used");
    AST_ADJ_READ: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (reg_req_in.rd && hit_adj) |=> reg_rdata_out == {8'h00, $past(rate_adjust)})
        else $error("rate-adjust read not live");
    AST_HOLD: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (!run && !wr_cnt) |=> $stable(time_count))
        else $error("stopped counter moved");
    AST_W1C: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        wr_cnt |=> time_count == ($past(time_count) & ~$past(reg_req_in.wdata)))
        else $error("count write not bitwise clear");
    AST_RST_VAL: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        !$past(rst_b_in) |-> (normal_step == atcc_pkg::NSTEP_RST
                               && adjusted_step == atcc_pkg::ASTEP_RST
                               && capture_setup == atcc_pkg::CAP_CFG_RST))
        else $error("reset values wrong");

    // ============================================================
    // checks: wrap flag and rate adjust
    AST_WRAP_STICKY: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (wrap_flag && !(wr_wrap && reg_req_in.wdata[0])) |=> wrap_flag)
        else $error("wrap flag not sticky");
    AST_WRAP_CLEAR: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (wr_wrap && reg_req_in.wdata[0] && !wrapped) |=> !wrap_flag)
        else $error("wrap flag not cleared by writing one");
    AST_WRAP_QUIET: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (!wrap_flag && !wrapped) |=> !wrap_flag)
        else $error("wrap flag set without rollover");
    AST_WRAP_ROLL: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        wrapped |=> wrap_flag)
        else $error("rollover lost");
    AST_STOP_NO_WRAP: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (!run && !wr_wrap) |=> $stable(wrap_flag))
        else $error("stopped counter changed wrap flag");
    AST_ADJ_LOAD: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        wr_adj |=> rate_adjust == $past(reg_req_in.wdata[atcc_pkg::ADJ_HI:0]))
        else $error("rate-adjust write not loaded");
    AST_ADJ_IDLE: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (!adj_active && !wr_adj) |=> rate_adjust == 24'h000000)
        else $error("rate-adjust count left zero by itself");
    AST_ADJ_DOWN: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        !wr_adj |=> rate_adjust <= $past(rate_adjust))
        else $error("rate-adjust count grew without a write");

    // ============================================================
    // checks: register reads and writes
    AST_CFG_WRITE: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        wr_cfg |=> (normal_step == $past(reg_req_in.wdata[atcc_pkg::NSTEP_HI:atcc_pkg::NSTEP_LO])
            && adjusted_step == $past(reg_req_in.wdata[atcc_pkg::ASTEP_HI:atcc_pkg::ASTEP_LO])))
        else $error("configuration write not stored");
    AST_RUN_WRITE: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        wr_cfg |=> run == $past(reg_req_in.wdata[atcc_pkg::RUN_BIT]))
        else $error("run bit write not stored");
    AST_CFG_READ: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (reg_req_in.rd && hit_cfg)
        |=> (reg_rdata_out[atcc_pkg::NSTEP_HI:atcc_pkg::NSTEP_LO] == $past(normal_step)
            && reg_rdata_out[atcc_pkg::ASTEP_HI:atcc_pkg::ASTEP_LO] == $past(adjusted_step)
            && reg_rdata_out[atcc_pkg::RUN_BIT] == $past(run)))
        else $error("configuration read wrong");
    AST_CNT_READ: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (reg_req_in.rd && hit_cnt) |=> reg_rdata_out == $past(time_count))
        else $error("count read wrong");
    AST_WRAP_READ: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (reg_req_in.rd && hit_wrap) |=> reg_rdata_out == {31'h00000000, $past(wrap_flag)})
        else $error("wrap flag read wrong");
    AST_CCFG_WRITE: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        wr_ccfg |=> capture_setup == $past(reg_req_in.wdata[atcc_pkg::SYNC_HI:0]))
        else $error("capture setup write not stored");
    AST_CCFG_READ: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (reg_req_in.rd && hit_ccfg) |=> reg_rdata_out == {14'h0000, $past(capture_setup)})
        else $error("capture setup read wrong");

    // ============================================================
    // checks: capture status and values
    AST_STS_READ: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (reg_req_in.rd && hit_csts) |=> reg_rdata_out
            == {8'h00, $past(level), 5'h00, |$past(slot_valid), $past(slot_valid)})
        else $error("capture status read wrong");
    AST_STS_CLEAR: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (rd_csts && slot_event == 10'h000) |=> slot_valid == 10'h000)
        else $error("status read did not clear valid bits");
    AST_CONT_NO_FLAG: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (slot_valid == 10'h000 && !wr_ccfg) |=> (slot_valid & ~mode) == 10'h000)
        else $error("continuous slot set its status");
    AST_VAL_READ: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (reg_req_in.rd && hit_cval && val_idx < 4'(atcc_pkg::N_SLOTS))
        |=> reg_rdata_out == $past(slot_value[val_idx]))
        else $error("capture value read wrong");
endmodule // atcc_timer

// [testbench/atcc_event_src.sv]
// far-side model: the external event lines that feed the capture inputs
// assumes the bench sets the wanted line levels on its falling-edge schedule
// ============================================================
// event line source
module atcc_event_src (
    input  wire logic       ref_clk_in,
    input  wire logic [7:0] level_in,
    output logic      [7:0] cap_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial cap_out = 8'h00;

    // lines move only after a falling edge, so they stay synchronous to the
    // timer clock and synchronisation may be switched off safely
    always @(negedge ref_clk_in) begin
        cap_out <= level_in;
    end
endmodule // atcc_event_src

// [testbench/atcc_timer_tb_top.sv]
// self-checking bench of the adjustable time counter with capture
// assumes one register request at a time; inputs move on the falling edge
// ============================================================
// bench top
module atcc_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic                ref_clk_in = 1'b0;
    logic                rst_b_in   = 1'b0;
    atcc_pkg::atcc_req_s req        = '0;
    logic [7:0]          lvl        = 8'h00;
    logic [7:0]          cap_in;
    logic [31:0]         rdata;
    int                  n_fail     = 0;
    int                  num_checks = 0;
    integer              seed       = 32'hF5723928;
    logic [31:0]         r;
    logic [31:0]         c0;
    logic [31:0]         mask;
    logic [9:0]          mode;
    logic [7:0]          sync;
    logic [3:0]          nstep;
    logic [11:0]         astep;
    logic [31:0]         v [10];

    always #20 ref_clk_in = ~ref_clk_in;

    atcc_event_src src_u (.ref_clk_in(ref_clk_in), .level_in(lvl), .cap_out(cap_in));
    atcc_timer dut_u (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .reg_req_in(req),
                      .cap_in(cap_in), .reg_rdata_out(rdata));

    // ============================================================
    // helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one request held across one rising edge; read data is taken after it
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(negedge ref_clk_in);
        req.wr = w;
        req.rd = ~w;
        req.addr = a;
        req.wdata = d;
        @(negedge ref_clk_in);
        req = '0;
        r = rdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        acc(1'b0, a, 32'h00000000);
    endtask

    // ten cycles cover the worst synchroniser delay
    task automatic drive_lines(input logic [7:0] l);
        @(negedge ref_clk_in);
        lvl <= l;
        repeat (10) @(negedge ref_clk_in);
    endtask

    function automatic logic [31:0] exp_sts(input logic [9:0] hit, input logic [7:0] raw);
        return {8'h00, raw, 5'h00, |hit, hit};
    endfunction

    task automatic complete_run();
        $display("TB: checks=%0d failures=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ============================================================
    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge ref_clk_in);
        n_fail++;
        complete_run();
    end

    // ============================================================
    // main sequence
    initial begin
        repeat (20) @(negedge ref_clk_in);
        rst_b_in = 1'b1;
        rd(atcc_pkg::OFS_GLB_CFG);
        check(r, 32'h00000550);
        rd(atcc_pkg::OFS_CAP_CFG);
        check(r, 32'h0001FC00);
        rd(atcc_pkg::OFS_RATE_ADJ);
        check(r, 32'h00000000);
        rd(atcc_pkg::OFS_COUNT);
        check(r, 32'h00000000);
        rd(8'h40);
        check(r, 32'h00000000);
        nstep = 4'($random(seed) & 32'h7) + 4'h1;
        astep = 12'($random(seed)) | 12'h010;
        wr(atcc_pkg::OFS_GLB_CFG, {12'h000, astep, nstep, 4'h1});
        rd(atcc_pkg::OFS_COUNT);
        c0 = r;
        rd(atcc_pkg::OFS_COUNT);
        check(r - c0, 32'(nstep) * 32'h2);
        wr(atcc_pkg::OFS_RATE_ADJ, 32'h00000028);
        rd(atcc_pkg::OFS_RATE_ADJ);
        check(r, 32'h00000027);
        rd(atcc_pkg::OFS_COUNT);
        c0 = r;
        rd(atcc_pkg::OFS_COUNT);
        check(r - c0, 32'(astep) * 32'h2);
        repeat (50) @(negedge ref_clk_in);
        rd(atcc_pkg::OFS_RATE_ADJ);
        check(r, 32'h00000000);
        rd(atcc_pkg::OFS_COUNT);
        c0 = r;
        rd(atcc_pkg::OFS_COUNT);
        check(r - c0, 32'(nstep) * 32'h2);
        // capture: random modes and synchroniser choices on all eight lines
        mode = 10'($random(seed));
        sync = 8'($random(seed));
        wr(atcc_pkg::OFS_CAP_CFG, {14'h0000, sync, mode});
        rd(atcc_pkg::OFS_CAP_CFG);
        check(r, {14'h0000, sync, mode});
        drive_lines(8'hFF);
        for (int i = 0; i < 10; i++) begin
            rd(atcc_pkg::OFS_CAP_VAL0 + 8'(4 * i));
            v[i] = r;
        end
        drive_lines(8'h00);
        drive_lines(8'hFF);
        for (int i = 0; i < 10; i++) begin
            if (i != 7 && i != 9) begin
                rd(atcc_pkg::OFS_CAP_VAL0 + 8'(4 * i));
                check(32'(r === v[i]), 32'(mode[i]));
            end
        end
        rd(atcc_pkg::OFS_CAP_STS);
        check(r, exp_sts(mode, 8'hFF));
        rd(atcc_pkg::OFS_CAP_STS);
        check(r, exp_sts(10'h000, 8'hFF));
        // stop the counter, then clear chosen bits of the held count
        wr(atcc_pkg::OFS_GLB_CFG, {12'h000, astep, nstep, 4'h0});
        rd(atcc_pkg::OFS_COUNT);
        c0 = r;
        repeat (5) @(negedge ref_clk_in);
        rd(atcc_pkg::OFS_COUNT);
        check(r, c0);
        mask = $random(seed);
        wr(atcc_pkg::OFS_COUNT, mask);
        rd(atcc_pkg::OFS_COUNT);
        check(r, c0 & ~mask);
        // no rollover can happen in this short run, so the flag stays clear
        rd(atcc_pkg::OFS_WRAP);
        check(r, 32'h00000000);
        wr(atcc_pkg::OFS_WRAP, 32'h00000001);
        rd(atcc_pkg::OFS_WRAP);
        check(r, 32'h00000000);
        complete_run();
    end
endmodule // atcc_timer_tb_top
